/* hdl/dllc_defs.svh */
/*
 * timing counts and fixed figures of the delay-locked clock supervisor.
 * assumes a 20 MHz system clock that samples the source and feedback clocks.
 */
`ifndef DLLC_DEFS_SVH
`define DLLC_DEFS_SVH

// ============================================================
// system clock
`define DLLC_SYS_PERIOD_NS 50
// ============================================================
// tolerated period drift, in ns, and as cycles (rounded down, at least one)
`define DLLC_DRIFT_NS 1
`define DLLC_DRIFT_CYC ((`DLLC_DRIFT_NS / `DLLC_SYS_PERIOD_NS) < 1 ? 1 : (`DLLC_DRIFT_NS / `DLLC_SYS_PERIOD_NS))
// ============================================================
// delay line depth, in source cycles (allowed span is one to four)
`define DLLC_FILL_CYCLES 2
`define DLLC_FLUSH_CYCLES 2
`define DLLC_SHIFT_CYCLES 2
// ============================================================
// default count of aligned source cycles before lock
`define DLLC_LOCK_COUNT 16
// counter width
`define DLLC_CNT_W 16

`endif

/* hdl/dllc_pkg.sv */
/*
 * types of the delay-locked clock supervisor.
 * assumes nothing beyond the defs header.
 */
package dllc_pkg;
	// ============================================================
	// delay line occupancy
	typedef enum logic [1:0] {
		DLLC_IDLE,
		DLLC_FILL,
		DLLC_RUN,
		DLLC_FLUSH
	} dllc_line_type;
endpackage

/* hdl/dllc_top.sv */
/*
 * behavioural delay-locked clock cell: lock supervision and output clock continuity.
 * assumes source and feedback clocks are far slower than CLK_SYS and synchronous to it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dllc_defs.svh"

// What this block does
// R1: keeps lock under one ns period drift
// R2: large period change needs a reset
// R3: scan reconfiguration drops lock until reset
// R4: source pauses low, under 100 us
// R5: lock stays asserted through a clock pause
// R6: emits up to four cycles after stop
// R7: outputs absent one to four cycles on restart
// R8: phase shift reaches outputs cycles later
// R9: downstream waits for lock before use
// R10: second cascaded stage reset by delay cell
// R11: inverted doubled clock output provided
// R12: reset drops lock within four source cycles
// R13: doubled clock is 1x 25/75 before lock
// R14: lock after configurable aligned cycle count
module dllc_top
	import dllc_pkg::*;
#(
	parameter logic [`DLLC_CNT_W-1:0] LOCK_COUNT = `DLLC_LOCK_COUNT
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic SOURCE_CLOCK_IN,
	input wire logic FEEDBACK_CLOCK_IN,
	input wire logic DLL_RESET_IN,
	input wire logic SCAN_RECONFIG_IN,
	output logic ALIGNED_CLOCK_OUT,
	output logic DOUBLED_CLOCK_OUT,
	output logic DOUBLED_CLOCK_INVERTED_OUT,
	output logic LOCKED_OUT
);
	localparam int W = `DLLC_CNT_W;
	localparam logic [W-1:0] DRIFT = W'(`DLLC_DRIFT_CYC);
	localparam logic [2:0] FILL_N = 3'(`DLLC_FILL_CYCLES);
	localparam logic [2:0] FLUSH_N = 3'(`DLLC_FLUSH_CYCLES);
	localparam logic [2:0] SHIFT_N = 3'(`DLLC_SHIFT_CYCLES);
	localparam logic [W-1:0] CNT_MAX = {W{1'b1}};

	// ============================================================
	// state
	dllc_line_type line_r, line_nxt;
	logic [W-1:0] cnt_r, cnt_nxt;
	logic [W-1:0] period_r, period_nxt;
	logic [W-1:0] ph_r, ph_nxt;
	logic [W-1:0] lockcnt_r, lockcnt_nxt;
	logic [2:0] seq_r, seq_nxt;
	logic [2:0] shift_r, shift_nxt;
	logic src_d_r, src_d_nxt;
	logic fb_d_r, fb_d_nxt;
	logic fb_rose_r, fb_rose_nxt;
	logic locked_r, locked_nxt;
	logic scan_lost_r, scan_lost_nxt;
	logic aligned_r, aligned_nxt;
	logic doubled_r, doubled_nxt;
	logic doubled_inv_r, doubled_inv_nxt;

	logic src_rise, fb_rise, ph_wrap, running, drift_ok, fb_aligned;
	logic [W-1:0] measured, diff, half, quarter, ph_step;

	// ============================================================
	// edge detection and period comparison
	always_comb begin
		src_rise = SOURCE_CLOCK_IN & ~src_d_r;
		fb_rise = FEEDBACK_CLOCK_IN & ~fb_d_r;
		fb_aligned = fb_rise | fb_rose_r;
		measured = (cnt_r == CNT_MAX) ? cnt_r : W'(cnt_r + 1'b1);
		diff = (measured >= period_r) ? W'(measured - period_r) : W'(period_r - measured);
		drift_ok = (diff <= DRIFT); // R1
		half = period_r >> 1;
		quarter = period_r >> 2;
		ph_wrap = (ph_r >= W'(period_r - 1'b1));
		ph_step = ph_wrap ? '0 : W'(ph_r + 1'b1);
	end

	// ============================================================
	// next state of the delay line, phase and lock supervisor
	always_comb begin
		line_nxt = line_r;
		cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : W'(cnt_r + 1'b1);
		period_nxt = period_r;
		ph_nxt = ph_step;
		lockcnt_nxt = lockcnt_r;
		seq_nxt = seq_r;
		shift_nxt = shift_r;
		src_d_nxt = SOURCE_CLOCK_IN;
		fb_d_nxt = FEEDBACK_CLOCK_IN;
		fb_rose_nxt = fb_rise;
		locked_nxt = locked_r;
		scan_lost_nxt = scan_lost_r | SCAN_RECONFIG_IN; // R3
		if (src_rise) begin
			cnt_nxt = '0;
		end
		unique case (line_r)
			DLLC_IDLE: begin
				if (src_rise) begin
					line_nxt = DLLC_FILL;
					seq_nxt = 3'h1;
					ph_nxt = '0;
				end
			end
			DLLC_FILL: begin
				// refilling: first period after a restart is measured only while unlocked, lock untouched
				if (src_rise) begin
					ph_nxt = '0;
					if (seq_r >= FILL_N) begin // R7
						line_nxt = DLLC_RUN;
						seq_nxt = '0;
					end else begin
						seq_nxt = 3'(seq_r + 1'b1);
					end
					if (seq_r == 3'h1) begin
						period_nxt = locked_r ? period_r : measured;
					end
				end
			end
			DLLC_RUN: begin
				if (src_rise) begin
					if (!locked_r) begin
						period_nxt = measured;
						ph_nxt = '0;
					end else if (drift_ok) begin
						// small drift: follow the new period and realign at this edge
						period_nxt = measured; // R1
						ph_nxt = '0;
						shift_nxt = '0;
					end else if (ph_step != '0 && ph_r != '0) begin
						// phase moved: follow only after it persists
						if (shift_r >= W'(SHIFT_N - 1'b1)) begin // R8
							ph_nxt = '0;
							shift_nxt = '0;
						end else begin
							shift_nxt = 3'(shift_r + 1'b1);
						end
					end else begin
						shift_nxt = '0;
					end
					if (!locked_r && !scan_lost_r) begin
						if (fb_aligned && drift_ok) begin // R14
							lockcnt_nxt = W'(lockcnt_r + 1'b1);
							if (W'(lockcnt_r + 1'b1) >= LOCK_COUNT) begin
								locked_nxt = 1'b1;
							end
						end else begin
							lockcnt_nxt = '0;
						end
					end
				end else if (cnt_r >= W'(period_r + half)) begin
					// edge missed by half a period: source paused, lock is held
					// a shorter margin would take a phase shift for a pause
					line_nxt = DLLC_FLUSH; // R5
					seq_nxt = '0;
				end
			end
			DLLC_FLUSH: begin
				if (src_rise) begin
					line_nxt = DLLC_FILL;
					seq_nxt = 3'h1;
					ph_nxt = '0;
				end else if (ph_wrap) begin
					if (W'(seq_r + 1'b1) >= W'(FLUSH_N)) begin // R6
						line_nxt = DLLC_IDLE;
						seq_nxt = '0;
					end else begin
						seq_nxt = 3'(seq_r + 1'b1);
					end
				end
			end
		endcase
		if (scan_lost_nxt) begin
			locked_nxt = 1'b0; // R3
			lockcnt_nxt = '0;
		end
		// cell reset: taps to zero, lock dropped at the next edge
		if (DLL_RESET_IN) begin
			line_nxt = DLLC_IDLE; // R2
			period_nxt = '0;
			ph_nxt = '0;
			lockcnt_nxt = '0;
			seq_nxt = '0;
			shift_nxt = '0;
			locked_nxt = 1'b0; // R12
			scan_lost_nxt = SCAN_RECONFIG_IN; // R3
		end
	end

	// ============================================================
	// output clock shaping
	always_comb begin
		// follow the next line state, so no runt pulse is left when the line empties
		running = (line_nxt == DLLC_RUN) | (line_nxt == DLLC_FLUSH);
		aligned_nxt = 1'b0;
		doubled_nxt = 1'b0;
		doubled_inv_nxt = 1'b0;
		if (running && !DLL_RESET_IN) begin
			aligned_nxt = (ph_nxt < half);
			if (locked_r) begin
				doubled_nxt = (ph_nxt < quarter) | ((ph_nxt >= half) & (ph_nxt < W'(half + quarter)));
				doubled_inv_nxt = ~doubled_nxt; // R11
			end else begin
				doubled_nxt = (ph_nxt < quarter); // R13
				doubled_inv_nxt = ~doubled_nxt;
			end
		end
	end

	// ============================================================
	// registers
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			line_r <= DLLC_IDLE;
			cnt_r <= '0;
			period_r <= '0;
			ph_r <= '0;
			lockcnt_r <= '0;
			seq_r <= '0;
			shift_r <= '0;
			src_d_r <= 1'b0;
			fb_d_r <= 1'b0;
			fb_rose_r <= 1'b0;
			locked_r <= 1'b0;
			scan_lost_r <= 1'b0;
			aligned_r <= 1'b0;
			doubled_r <= 1'b0;
			doubled_inv_r <= 1'b0;
		end else begin
			line_r <= line_nxt;
			cnt_r <= cnt_nxt;
			period_r <= period_nxt;
			ph_r <= ph_nxt;
			lockcnt_r <= lockcnt_nxt;
			seq_r <= seq_nxt;
			shift_r <= shift_nxt;
			src_d_r <= src_d_nxt;
			fb_d_r <= fb_d_nxt;
			fb_rose_r <= fb_rose_nxt;
			locked_r <= locked_nxt;
			scan_lost_r <= scan_lost_nxt;
			aligned_r <= aligned_nxt;
			doubled_r <= doubled_nxt;
			doubled_inv_r <= doubled_inv_nxt;
		end
	end

	assign ALIGNED_CLOCK_OUT = aligned_r;
	assign DOUBLED_CLOCK_OUT = doubled_r;
	assign DOUBLED_CLOCK_INVERTED_OUT = doubled_inv_r;
	assign LOCKED_OUT = locked_r;
endmodule // dllc_top

`default_nettype wire

/* test/dllc_checker.sv */
/* port checks of the clock cell.
   assumes RESET_N is the async reset and CLK_SYS samples every port. */
`timescale 1ns/100ps
`default_nettype none
module dllc_checker
	import dllc_pkg::*;
#(
	parameter logic [15:0] LOCK_COUNT = 16'h0010
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic SOURCE_CLOCK_IN,
	input wire logic FEEDBACK_CLOCK_IN,
	input wire logic DLL_RESET_IN,
	input wire logic SCAN_RECONFIG_IN,
	input wire logic ALIGNED_CLOCK_OUT,
	input wire logic DOUBLED_CLOCK_OUT,
	input wire logic DOUBLED_CLOCK_INVERTED_OUT,
	input wire logic LOCKED_OUT
);
	logic lost_r, lost_nxt, src_r;
	logic [15:0] rise_r, rise_nxt;
	// ============================================================
	// helpers: scan loss flag, source rises since reset
	always_comb begin
		lost_nxt = SCAN_RECONFIG_IN || (!DLL_RESET_IN && lost_r);
		rise_nxt = DLL_RESET_IN ? 16'h0000 : rise_r + (SOURCE_CLOCK_IN && !src_r && !(&rise_r));
	end
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			lost_r <= 1'b0;
			src_r <= 1'b0;
			rise_r <= 16'h0000;
		end else begin
			lost_r <= lost_nxt;
			src_r <= SOURCE_CLOCK_IN;
			rise_r <= rise_nxt;
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	sequence s_cell_reset;
		DLL_RESET_IN;
	endsequence
	a_reset_drops_lock: assert property (s_cell_reset |=> !LOCKED_OUT) else $error("lock after reset");
	a_reset_stops_clocks: assert property (s_cell_reset |=> !ALIGNED_CLOCK_OUT && !DOUBLED_CLOCK_OUT)
		else $error("clock after reset");
	a_lock_not_early: assert property (s_cell_reset |=> !LOCKED_OUT [*3]) else $error("early lock");
	a_lock_needs_count: assert property ($rose(LOCKED_OUT) |-> rise_r >= LOCK_COUNT)
		else $error("lock too soon");
	a_lock_holds: assert property (LOCKED_OUT && !DLL_RESET_IN && !SCAN_RECONFIG_IN |=> LOCKED_OUT)
		else $error("lock lost");
	a_scan_blocks_lock: assert property (lost_r |-> !LOCKED_OUT) else $error("lock while scan lost");
	a_prelock_quarter: assert property (!LOCKED_OUT && DOUBLED_CLOCK_OUT |-> ALIGNED_CLOCK_OUT)
		else $error("doubled high outside first half");
	a_inverted_pair: assert property (DOUBLED_CLOCK_INVERTED_OUT |-> !DOUBLED_CLOCK_OUT)
		else $error("inverted clock overlaps");
endmodule // dllc_checker
bind dllc_top dllc_checker #(.LOCK_COUNT(LOCK_COUNT)) dllc_checker_i (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
	.SOURCE_CLOCK_IN(SOURCE_CLOCK_IN), .FEEDBACK_CLOCK_IN(FEEDBACK_CLOCK_IN), .DLL_RESET_IN(DLL_RESET_IN),
	.SCAN_RECONFIG_IN(SCAN_RECONFIG_IN), .ALIGNED_CLOCK_OUT(ALIGNED_CLOCK_OUT), .DOUBLED_CLOCK_OUT(DOUBLED_CLOCK_OUT),
	.DOUBLED_CLOCK_INVERTED_OUT(DOUBLED_CLOCK_INVERTED_OUT), .LOCKED_OUT(LOCKED_OUT));
`default_nettype wire

/* test/dllc_src_model.sv */
/* source clock model: pauses only in its low half, feedback looped back.
   assumes it is stepped on the falling edge of the system clock. */
`timescale 1ns/100ps
`default_nettype none
module dllc_src_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [5:0] per,
	output logic src,
	output logic fb
);
	logic [5:0] cnt_r, cnt_nxt;
	// ============================================================
	// period counter, frozen low on a pause so a full high half follows
	always_comb begin
		cnt_nxt = (cnt_r + 6'h01 >= per) ? 6'h00 : cnt_r + 6'h01;
		if (!run && !src) cnt_nxt = cnt_r;
	end
	always_ff @(negedge clk or negedge rst_n) begin
		if (!rst_n) cnt_r <= 6'h00;
		else cnt_r <= cnt_nxt;
	end
	assign src = cnt_r < (per >> 1);
	assign fb = src; // feedback already aligned with the source
endmodule // dllc_src_model
`default_nettype wire

/* test/dllc_top_tb.sv */
/* self-checking bench of the clock cell with a source model.
   assumes the checker binds itself from its own file. */
`timescale 1ns/100ps
`default_nettype none
module dllc_top_tb;
	localparam logic [15:0] LC = 16'h0004;
	logic clk = 1'b0, rst_n = 1'b0, rst_cell = 1'b0, scan = 1'b0, run = 1'b1, fb_ok = 1'b1;
	logic [3:0] rst_dly = 4'h0;
	logic src, fb, al, db, dbi, lk;
	logic [5:0] per = 6'h10;
	logic [31:0] x = 32'h00014FAC;
	int fails = 0, checks_done = 0, ns, na, nd, ni, i;
	always #25 clk = !clk;
	// shift-register delay of the chip reset, as a cascaded second stage needs
	always @(negedge clk) rst_dly <= {rst_dly[2:0], rst_n};
	dllc_top #(.LOCK_COUNT(LC)) dllc_top_i (.CLK_SYS(clk), .RESET_N(rst_n), .SOURCE_CLOCK_IN(src),
		.FEEDBACK_CLOCK_IN(fb & fb_ok), .DLL_RESET_IN(rst_cell), .SCAN_RECONFIG_IN(scan), .ALIGNED_CLOCK_OUT(al),
		.DOUBLED_CLOCK_OUT(db), .DOUBLED_CLOCK_INVERTED_OUT(dbi), .LOCKED_OUT(lk));
	dllc_src_model dllc_src_model_i (.clk(clk), .rst_n(rst_n), .run(run), .per(per), .src(src), .fb(fb));
	// ============================================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	function automatic logic span(input int n, input int lo, input int hi);
		return n >= lo && n <= hi;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// counts source rises and lock or aligned rises, optionally stopping at the latter
	task automatic watch(input int cyc, input bit sel, input bit stop);
		logic ps, pw, w, pd, pi;
		ns = 0;
		na = 0;
		nd = 0;
		ni = 0;
		ps = src;
		pw = sel ? lk : al;
		pd = db;
		pi = dbi;
		repeat (cyc) begin
			@(negedge clk);
			w = sel ? lk : al;
			ns += int'(src && !ps);
			na += int'(w && !pw);
			nd += int'(db && !pd);
			ni += int'(dbi && !pi);
			ps = src;
			pw = w;
			pd = db;
			pi = dbi;
			if (stop && na > 0) break;
		end
	endtask
	// one-cycle pulse of scan or cell reset; lock must be gone next cycle
	task automatic pulse(input bit sc);
		@(negedge clk);
		{scan, rst_cell} <= sc ? 2'b10 : 2'b01;
		@(negedge clk);
		{scan, rst_cell} <= 2'b00;
		chk(lk, 1'b0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#(60000 * 50);
		fails++;
		tally_and_finish;
	end
	// ============================================================
	// random periods: lock, drift, pause, phase shift; then scan loss
	initial begin
		repeat (6) @(negedge clk);
		rst_n <= 1'b1;
		wait (rst_dly[3]);
		for (i = 0; i < 3; i++) begin
			x = nxt(x);
			per <= 6'h10 + {2'b00, x[3:0]};
			pulse(1'b0);
			chk(al, 1'b0);
			watch(3000, 1'b1, 1'b1);
			chk(span(ns, LC, LC + 6), 1'b1);
			chk(span(nd, 1, ns), 1'b1);
			chk(lk, 1'b1);
			per <= per + 6'h01;
			watch(300, 1'b1, 1'b0);
			chk(lk, 1'b1);
			chk(span(nd, 2 * ns - 2, 2 * ns + 2), 1'b1);
			chk(span(ni, 2 * ns - 2, 2 * ns + 2), 1'b1);
			run <= 1'b0;
			wait (!src);
			watch(100 + x[6:0], 1'b0, 1'b0);
			chk(span(na, 1, 4), 1'b1);
			chk(lk, 1'b1);
			run <= 1'b1;
			watch(200, 1'b0, 1'b1);
			chk(span(ns, 1, 4), 1'b1);
			chk(lk, 1'b1);
			per <= per + 6'h03;
			watch(40, 1'b0, 1'b0);
			per <= per - 6'h03;
			watch(200, 1'b0, 1'b0);
			chk(lk, 1'b1);
			wait (!src);
			wait (src);
			watch(3, 1'b0, 1'b1);
			chk(na, 16'h0001);
		end
		pulse(1'b1);
		watch(1000, 1'b1, 1'b1);
		chk(na, 16'h0000);
		fb_ok <= 1'b0;
		pulse(1'b0);
		watch(600, 1'b1, 1'b1);
		chk(na, 16'h0000);
		fb_ok <= 1'b1;
		watch(3000, 1'b1, 1'b1);
		chk(lk, 1'b1);
		tally_and_finish;
	end
endmodule // dllc_top_tb
`default_nettype wire
